// File: core/mcl_core.v
`timescale 1ns/10ps
`include "mcl_regs.vh"
// Functional notes
// - six inputs, each scaled separately
// - input to percent of min..max span
// - stages chain result into next A
// - source B zero passes A through
// - codes 0-5 are comparisons
// - codes 6-8 are OR AND XOR
// - codes 9-14 arithmetic and min/max
// - logic operand true when at least one
// - compare and logic give 0 or 1
// - divide by zero gives full scale
// - percent mapped to physical output range
// - latch starts off, reset dominates set
// - latch holds after set released
// - reset on forces output off
// - each latch source has own thresholds
module mcl_core #(
  parameter NIN = 6 // number of math inputs
) (
  input wire mclk,                    // clock
  input wire rst,                     // async reset, active high
  input wire [7:0] avs_address,       // byte address
  input wire avs_read,                // read strobe
  input wire avs_write,               // write strobe
  input wire [31:0] avs_writedata,    // write data
  input wire [3:0] avs_byteenable,    // byte enables
  output reg [31:0] avs_readdata,     // read data
  output reg avs_waitrequest,         // wait request
  output reg [15:0] math_pct,         // math result percent
  output reg [15:0] math_phys,        // math result physical
  output reg latch_out                // set/reset latch output
);
  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  reg run;
  reg [15:0] in_val [0:NIN-1];
  reg [15:0] in_min [0:NIN-1];
  reg [15:0] in_max [0:NIN-1];
  reg [1:0] in_dec [0:NIN-1];
  reg [15:0] out_min;
  reg [15:0] out_max;
  reg [15:0] set_lo, set_hi, rst_lo, rst_hi;
  reg [2:0] set_sel, rst_sel;
  reg [15:0] op_codes;
  reg [14:0] src_codes;
  reg set_st, rst_st;
  reg done;
  integer i;
  integer j;
  wire sel_hit = (avs_read | avs_write) & avs_waitrequest;
  wire [2:0] widx = avs_address[4:2];
  function [15:0] merge;
    input [15:0] old;
    input [31:0] d;
    input [3:0] be;
    begin
      merge = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
    end
  endfunction
  // source field is 15 bits wide; the merge works on a whole 16-bit half
  wire [15:0] src_merged = merge({1'b0, src_codes}, avs_writedata, avs_byteenable);
  // ----------------------------------------------------------------
  // input scaling
  // ----------------------------------------------------------------
  reg [15:0] pct [0:NIN];
  reg [31:0] num;
  reg [31:0] span;
  reg [31:0] q;
  reg [31:0] dv;
  always @* begin
    num = 32'h0;
    span = 32'h0;
    q = 32'h0;
    dv = 32'h0;
    pct[0] = 16'h0000;
    for (i = 0; i < NIN; i = i + 1) begin
      // decimal digits (in_dec) are not applied; value and limits are used as written
      dv = {16'h0, in_val[i]};
      span = {16'h0, in_max[i]} - {16'h0, in_min[i]};
      if (in_max[i] <= in_min[i] || in_val[i] <= in_min[i]) begin
        q = 32'h0;
      end else if (in_val[i] >= in_max[i]) begin
        q = {16'h0, `MCL_FULL};
      end else begin
        num = (dv - {16'h0, in_min[i]}) * {16'h0, `MCL_FULL};
        q = num / span;
      end
      pct[i+1] = q[15:0];
    end
  end
  // ----------------------------------------------------------------
  // operator chain
  // ----------------------------------------------------------------
  wire [15:0] chain [0:4];
  wire [15:0] opb [0:3];
  wire [2:0] src_a = src_codes[2:0];
  assign chain[0] = (src_a == `MCL_SRC_NONE || src_a > NIN) ? 16'h0000 : pct[src_a];
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : stg
      wire [2:0] sb = src_codes[3*g+5:3*g+3];
      assign opb[g] = (sb > NIN) ? 16'h0000 : pct[sb];
      mcl_stage u_stage (
        .op(op_codes[4*g+3:4*g]),
        .use_b(sb != `MCL_SRC_NONE && sb <= NIN),
        .a(chain[g]),
        .b(opb[g]),
        .y(chain[g+1])
      );
    end
  endgenerate
  // ----------------------------------------------------------------
  // output scaling and latch sources
  // ----------------------------------------------------------------
  // select codes above the input count read as zero instead of an absent entry
  wire [15:0] set_pct = (set_sel > NIN) ? 16'h0000 : pct[set_sel];
  wire [15:0] rst_pct = (rst_sel > NIN) ? 16'h0000 : pct[rst_sel];
  reg [31:0] ph;
  reg [15:0] next_phys;
  reg next_set, next_rst;
  always @* begin
    ph = (out_max >= out_min) ?
      (({16'h0, out_max} - {16'h0, out_min}) * {16'h0, chain[4]}) / {16'h0, `MCL_FULL} : 32'h0;
    next_phys = out_min + ph[15:0];
    // on at max, off at min, hold between
    next_set = set_st;
    if (set_pct >= set_hi) begin
      next_set = 1'b1;
    end else if (set_pct <= set_lo) begin
      next_set = 1'b0;
    end
    next_rst = rst_st;
    if (rst_pct >= rst_hi) begin
      next_rst = 1'b1;
    end else if (rst_pct <= rst_lo) begin
      next_rst = 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // evaluation and register bus
  // ----------------------------------------------------------------
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      run <= 1'b0;
      for (j = 0; j < NIN; j = j + 1) begin
        in_val[j] <= 16'h0000;
        in_min[j] <= 16'h0000;
        in_max[j] <= `MCL_FULL;
        in_dec[j] <= 2'h0;
      end
      out_min <= 16'h0000;
      out_max <= `MCL_FULL;
      set_lo <= 16'h0000;
      set_hi <= `MCL_FULL;
      rst_lo <= 16'h0000;
      rst_hi <= `MCL_FULL;
      set_sel <= 3'h0;
      rst_sel <= 3'h0;
      op_codes <= 16'h0000;
      src_codes <= 15'h0000;
      set_st <= 1'b0;
      rst_st <= 1'b0;
      done <= 1'b0;
      math_pct <= 16'h0000;
      math_phys <= 16'h0000;
      latch_out <= 1'b0;
      avs_readdata <= 32'h0000_0000;
      avs_waitrequest <= 1'b1;
    end else begin
      if (run) begin
        math_pct <= chain[4];
        math_phys <= next_phys;
        set_st <= next_set;
        rst_st <= next_rst;
        if (next_rst) begin
          latch_out <= 1'b0;
        end else if (next_set) begin
          latch_out <= 1'b1;
        end
        done <= 1'b1;
      end
      avs_waitrequest <= 1'b1;
      if (sel_hit) begin
        avs_waitrequest <= 1'b0;
        avs_readdata <= 32'h0000_0000;
        if (avs_write) begin
          if (avs_address == `MCL_A_CTRL && avs_byteenable[0]) run <= avs_writedata[`MCL_CTRL_RUN];
          if (avs_address == `MCL_A_OUTMIN) out_min <= merge(out_min, avs_writedata, avs_byteenable);
          if (avs_address == `MCL_A_OUTMAX) out_max <= merge(out_max, avs_writedata, avs_byteenable);
          if (avs_address == `MCL_A_OPCFG) op_codes <= merge(op_codes, avs_writedata, avs_byteenable);
          if (avs_address == `MCL_A_SRCCFG) src_codes <= src_merged[14:0];
          if (avs_address == `MCL_A_LATSRC && avs_byteenable[0]) begin
            set_sel <= avs_writedata[2:0];
            rst_sel <= avs_writedata[6:4];
          end
          if (avs_address == `MCL_A_LATCFG) begin
            if (avs_byteenable[1:0] == 2'h3) set_hi <= avs_writedata[15:0];
            if (avs_byteenable[3:2] == 2'h3) rst_hi <= avs_writedata[31:16];
          end
          if (avs_address == `MCL_A_STAT) begin
            if (avs_byteenable[1:0] == 2'h3) set_lo <= avs_writedata[15:0];
            if (avs_byteenable[3:2] == 2'h3) rst_lo <= avs_writedata[31:16];
          end
          if (widx < NIN) begin
            if (avs_address[7:5] == `MCL_A_IN_BASE >> 5)
              in_val[widx] <= merge(in_val[widx], avs_writedata, avs_byteenable);
            if (avs_address[7:5] == `MCL_A_MIN_BASE >> 5)
              in_min[widx] <= merge(in_min[widx], avs_writedata, avs_byteenable);
            if (avs_address[7:5] == `MCL_A_MAX_BASE >> 5)
              in_max[widx] <= merge(in_max[widx], avs_writedata, avs_byteenable);
            if (avs_address[7:5] == `MCL_A_DEC_BASE >> 5 && avs_byteenable[0])
              in_dec[widx] <= avs_writedata[1:0];
          end
        end else begin
          case (avs_address)
            `MCL_A_CTRL: avs_readdata <= {31'h0, run};
            `MCL_A_STAT: avs_readdata <= {rst_lo, set_lo};
            `MCL_A_RESULT: avs_readdata <= {13'h0, done, rst_st, set_st, math_pct};
            `MCL_A_PHYS: avs_readdata <= {15'h0, latch_out, math_phys};
            `MCL_A_OUTMIN: avs_readdata <= {16'h0, out_min};
            `MCL_A_OUTMAX: avs_readdata <= {16'h0, out_max};
            `MCL_A_LATCFG: avs_readdata <= {rst_hi, set_hi};
            `MCL_A_LATSRC: avs_readdata <= {25'h0, rst_sel, 1'b0, set_sel};
            `MCL_A_OPCFG: avs_readdata <= {16'h0, op_codes};
            `MCL_A_SRCCFG: avs_readdata <= {17'h0, src_codes};
            default: begin
              if (widx < NIN && avs_address[7:5] == `MCL_A_IN_BASE >> 5)
                avs_readdata <= {16'h0, in_val[widx]};
              else if (widx < NIN && avs_address[7:5] == `MCL_A_MIN_BASE >> 5)
                avs_readdata <= {16'h0, in_min[widx]};
              else if (widx < NIN && avs_address[7:5] == `MCL_A_MAX_BASE >> 5)
                avs_readdata <= {16'h0, in_max[widx]};
              else if (widx < NIN && avs_address[7:5] == `MCL_A_DEC_BASE >> 5)
                avs_readdata <= {30'h0, in_dec[widx]};
              else
                avs_readdata <= 32'h0000_0000;
            end
          endcase
        end
      end
    end
  end
endmodule // mcl_core

// File: core/mcl_regs.vh
`ifndef MCL_REGS_VH
`define MCL_REGS_VH
// register byte addresses
`define MCL_A_CTRL     8'h00
`define MCL_A_STAT     8'h04
`define MCL_A_RESULT   8'h08
`define MCL_A_PHYS     8'h0C
`define MCL_A_OUTMIN   8'h10
`define MCL_A_OUTMAX   8'h14
`define MCL_A_LATCFG   8'h18
`define MCL_A_LATSRC   8'h1C
`define MCL_A_OPCFG    8'h20
`define MCL_A_SRCCFG   8'h24
`define MCL_A_IN_BASE  8'h40
`define MCL_A_MIN_BASE 8'h60
`define MCL_A_MAX_BASE 8'h80
`define MCL_A_DEC_BASE 8'hA0
// operator codes
`define MCL_OP_EQ  4'h0
`define MCL_OP_NE  4'h1
`define MCL_OP_GT  4'h2
`define MCL_OP_GE  4'h3
`define MCL_OP_LT  4'h4
`define MCL_OP_LE  4'h5
`define MCL_OP_OR  4'h6
`define MCL_OP_AND 4'h7
`define MCL_OP_XOR 4'h8
`define MCL_OP_ADD 4'h9
`define MCL_OP_SUB 4'hA
`define MCL_OP_MUL 4'hB
`define MCL_OP_DIV 4'hC
`define MCL_OP_MIN 4'hD
`define MCL_OP_MAX 4'hE
// percentage fixed point: 100% = 10000 (0.01 % steps)
`define MCL_FULL   16'h2710
`define MCL_ONE    16'h0064
`define MCL_SRC_NONE 3'h0
`define MCL_CTRL_RUN 0
`endif

// File: core/mcl_stage.v
`timescale 1ns/10ps
`include "mcl_regs.vh"
// one operator stage: a op b, result in percentage units, saturating to 0..full
module mcl_stage (
  input wire [3:0] op,      // operator code
  input wire use_b,         // operand b selected
  input wire [15:0] a,      // operand a
  input wire [15:0] b,      // operand b
  output reg [15:0] y       // stage result
);
  reg ta;
  reg tb;
  reg [31:0] wide;
  always @* begin
    ta = (a >= `MCL_ONE);
    tb = (b >= `MCL_ONE);
    wide = 32'h0;
    y = a;
    if (use_b) begin
      case (op)
        // boolean as 0/1
        // true is one percent so that a later logic stage still reads it as true
        `MCL_OP_EQ: y = (a == b) ? `MCL_ONE : 16'h0000;
        `MCL_OP_NE: y = (a != b) ? `MCL_ONE : 16'h0000;
        `MCL_OP_GT: y = (a > b) ? `MCL_ONE : 16'h0000;
        `MCL_OP_GE: y = (a >= b) ? `MCL_ONE : 16'h0000;
        `MCL_OP_LT: y = (a < b) ? `MCL_ONE : 16'h0000;
        `MCL_OP_LE: y = (a <= b) ? `MCL_ONE : 16'h0000;
        `MCL_OP_OR: y = (ta | tb) ? `MCL_ONE : 16'h0000;
        `MCL_OP_AND: y = (ta & tb) ? `MCL_ONE : 16'h0000;
        `MCL_OP_XOR: y = (ta ^ tb) ? `MCL_ONE : 16'h0000;
        `MCL_OP_ADD: begin
          wide = {16'h0, a} + {16'h0, b};
          y = (wide > {16'h0, `MCL_FULL}) ? `MCL_FULL : wide[15:0];
        end
        `MCL_OP_SUB: y = (b > a) ? 16'h0000 : a - b;
        `MCL_OP_MUL: begin
          wide = (a * b) / {16'h0, `MCL_FULL};
          y = (wide > {16'h0, `MCL_FULL}) ? `MCL_FULL : wide[15:0];
        end
        `MCL_OP_DIV: begin
          if (b == 16'h0000) begin
            y = `MCL_FULL;
          end else begin
            wide = ({16'h0, a} * {16'h0, `MCL_FULL}) / {16'h0, b};
            y = (wide > {16'h0, `MCL_FULL}) ? `MCL_FULL : wide[15:0];
          end
        end
        `MCL_OP_MIN: y = (a < b) ? a : b;
        `MCL_OP_MAX: y = (a > b) ? a : b;
        default: y = a;
      endcase
    end
  end
endmodule // mcl_stage

// File: sim/mcl_core_props.sv
`timescale 1ns/10ps
`include "mcl_regs.vh"
module mcl_core_chk #(
  parameter NIN = 6
) (
  input wire mclk, // clock
  input wire rst, // reset
  input wire [7:0] avs_address, // address
  input wire avs_read, // read
  input wire avs_write, // write
  input wire [31:0] avs_writedata, // wdata
  input wire [31:0] avs_readdata, // rdata
  input wire avs_waitrequest, // stall
  input wire [15:0] math_pct, // percent
  input wire [15:0] math_phys, // physical
  input wire latch_out // latch
);
  logic run_q;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // ----
  // checks
  // ----
  // shadow of the run bit: outputs must freeze while it is clear
  // the block takes a write on the edge where waitrequest is still high
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      run_q <= 1'b0;
    end else if (avs_write && avs_waitrequest && avs_address == `MCL_A_CTRL) begin
      run_q <= avs_writedata[0];
    end
  end
  chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("wait low too long");
  chk_wait_answer: assert property ($rose(avs_read || avs_write) |-> ##[1:3] !avs_waitrequest)
    else $error("no answer");
  chk_wait_cause: assert property (!avs_waitrequest |-> $past(avs_read || avs_write))
    else $error("answer without request");
  chk_idle_release: assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("answer while idle");
  chk_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address == 8'hFC |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  chk_rd_stands: assert property (!avs_read && !avs_write |=> $stable(avs_readdata))
    else $error("read data moved");
  chk_pct_range: assert property (math_pct <= `MCL_FULL)
    else $error("percent over full scale");
  chk_stop_hold: assert property (!run_q |=> $stable(math_pct) && $stable(math_phys) && $stable(latch_out))
    else $error("output moved while stopped");
endmodule // mcl_core_chk
bind mcl_core mcl_core_chk #(.NIN(NIN)) u_chk (.mclk(mclk), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .math_pct(math_pct), .math_phys(math_phys), .latch_out(latch_out));

// File: sim/mcl_host.sv
`timescale 1ns/10ps
module mcl_host (
  input wire mclk, // clock
  input wire avs_waitrequest, // stall
  input wire [31:0] avs_readdata, // rdata
  output logic [7:0] avs_address = 8'h00, // address
  output logic avs_read = 1'b0, // read
  output logic avs_write = 1'b0, // write
  output logic [31:0] avs_writedata = 32'h0 // wdata
);
  // ----
  // bus master
  // ----
  // one access at a time; request held until waitrequest is seen low
  task acc(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge mclk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    @(posedge mclk);
    while (avs_waitrequest !== 1'b0) @(posedge mclk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
endmodule // mcl_host

// File: sim/test_math_chain_and_latch_blocks.sv
`timescale 1ns/10ps
`include "mcl_regs.vh"
module test_math_chain_and_latch_blocks;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  wire [7:0] avs_address;
  wire avs_read;
  wire avs_write;
  wire [31:0] avs_writedata;
  wire [31:0] avs_readdata;
  wire avs_waitrequest;
  wire [15:0] math_pct;
  wire [15:0] math_phys;
  wire latch_out;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc = 0;
  int a, b, c, d;
  logic [31:0] q;
  int lat_s[7] = '{0, 9000, 0, 0, 9000, 9000, 9000};
  int lat_r[7] = '{0, 0, 0, 9000, 9000, 5000, 1000};
  logic lat_e[7] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};
  always #12.5 mclk = ~mclk;
  mcl_core #(.NIN(6)) DUT (.mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .math_pct(math_pct), .math_phys(math_phys), .latch_out(latch_out));
  mcl_host host (.mclk(mclk), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata));
  // ----
  // helpers
  // ----
  task end_sim;
    $display("compared %0d mismatched %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim;
    end
  end
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] ad, input logic [31:0] dat);
    host.acc(1'b1, ad, dat, q);
  endtask
  // evaluation is one cycle; a few spare edges cover the chain
  task settle;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
  endtask
  function automatic logic [15:0] f_op(input int op, input int x, input int y);
    int r;
    logic tx;
    logic ty;
    tx = x >= 100;
    ty = y >= 100;
    case (op)
      0: r = x == y;
      1: r = x != y;
      2: r = x > y;
      3: r = x >= y;
      4: r = x < y;
      5: r = x <= y;
      6: r = tx | ty;
      7: r = tx & ty;
      8: r = tx ^ ty;
      9: r = x + y;
      10: r = x - y;
      11: r = x * y / 10000;
      12: r = y == 0 ? 10000 : x * 10000 / y;
      13: r = x < y ? x : y;
      default: r = x > y ? x : y;
    endcase
    if (op < 9) r = r * 100;
    if (r < 0) r = 0;
    if (r > 10000) r = 10000;
    return r[15:0];
  endfunction
  // ----
  // tests
  // ----
  initial begin
    q = $urandom(36802);
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    chk(latch_out, 1'b0);
    chk(avs_waitrequest, 1'b1);
    wr(8'hFC, 32'hFFFFFFFF);
    host.acc(1'b0, 8'hFC, 32'h0, q);
    chk(q, 32'h0);
    for (int i = 0; i < 6; i++) begin
      wr(`MCL_A_MIN_BASE + 8'(4 * i), 32'h0);
      wr(`MCL_A_MAX_BASE + 8'(4 * i), 32'h2710);
    end
    wr(`MCL_A_OUTMIN, 32'h0);
    wr(`MCL_A_OUTMAX, 32'h2710);
    host.acc(1'b0, `MCL_A_OUTMAX, 32'h0, q);
    chk(q[15:0], 16'h2710);
    wr(`MCL_A_DEC_BASE + 8'h04, 32'h2);
    host.acc(1'b0, `MCL_A_DEC_BASE + 8'h04, 32'h0, q);
    chk(q, 32'h2);
    wr(`MCL_A_SRCCFG, 32'h11);
    wr(`MCL_A_CTRL, 32'h1);
    $display("setup done");
    // inputs kept inside the scaled span
    for (int op = 0; op < 15; op++) begin
      for (int k = 0; k < 4; k++) begin
        a = k == 2 ? 100 : $urandom_range(10000);
        b = k == 0 ? a : (k == 1 ? 0 : (k == 2 ? 99 : $urandom_range(10000)));
        wr(`MCL_A_IN_BASE, 32'(a));
        wr(`MCL_A_IN_BASE + 8'h04, 32'(b));
        wr(`MCL_A_OPCFG, 32'(op));
        settle;
        chk(math_pct, f_op(op, a, b));
        chk(math_phys, f_op(op, a, b));
      end
    end
    $display("operators done");
    a = $urandom_range(10000);
    b = $urandom_range(10000);
    c = $urandom_range(10000);
    d = $urandom_range(10000);
    wr(`MCL_A_IN_BASE, 32'(a));
    wr(`MCL_A_IN_BASE + 8'h04, 32'(b));
    wr(`MCL_A_IN_BASE + 8'h08, 32'(c));
    wr(`MCL_A_IN_BASE + 8'h0C, 32'(d));
    wr(`MCL_A_SRCCFG, 32'h8D1);
    wr(`MCL_A_OPCFG, 32'h0EA9);
    settle;
    chk(math_pct, f_op(14, f_op(10, f_op(9, a, b), c), d));
    wr(`MCL_A_IN_BASE + 8'h10, 32'(a));
    wr(`MCL_A_IN_BASE + 8'h14, 32'(b));
    wr(`MCL_A_SRCCFG, 32'h35);
    wr(`MCL_A_OPCFG, 32'hD);
    settle;
    chk(math_pct, f_op(13, a, b));
    $display("chain done");
    wr(`MCL_A_MIN_BASE, 32'h7D0);
    wr(`MCL_A_MAX_BASE, 32'h1770);
    wr(`MCL_A_IN_BASE, 32'hFA0);
    wr(`MCL_A_SRCCFG, 32'h1);
    wr(`MCL_A_OUTMIN, 32'h64);
    wr(`MCL_A_OUTMAX, 32'h4E84);
    settle;
    chk(math_pct, 16'h1388);
    chk(math_phys, 16'h2774);
    host.acc(1'b0, `MCL_A_RESULT, 32'h0, q);
    chk(q[15:0], 16'h1388);
    wr(`MCL_A_MIN_BASE, 32'h0);
    wr(`MCL_A_MAX_BASE, 32'h2710);
    $display("scaling done");
    wr(`MCL_A_LATSRC, 32'h21);
    wr(`MCL_A_STAT, 32'h07D0_07D0);
    wr(`MCL_A_LATCFG, 32'h1F40_1F40);
    for (int i = 0; i < 7; i++) begin
      wr(`MCL_A_IN_BASE, 32'(lat_s[i]));
      wr(`MCL_A_IN_BASE + 8'h04, 32'(lat_r[i]));
      settle;
      chk(latch_out, lat_e[i]);
    end
    wr(`MCL_A_CTRL, 32'h0);
    wr(`MCL_A_IN_BASE + 8'h04, 32'h2328);
    settle;
    chk(latch_out, 1'b1);
    $display("latch done");
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk(latch_out, 1'b0);
    end_sim;
  end
endmodule // test_math_chain_and_latch_blocks
